// file: design/state_event_timer.sv
// Contract
// R01 - Counter runs as two 16-bit halves or one unified 32-bit counter.
// R02 - State writes take effect only while the matching counter is halted.
// R03 - Current state holds values zero through thirty-one.
// R04 - Firing event loads or adds its state value per load-method flag.
// R05 - Highest-numbered firing state-changing event decides next state.
// R06 - Event fires only while current state's bit in its mask is set.
// R07 - Match events compare a selected match register; inputs/outputs may combine.
// R08 - Selected firing event copies the counter into assigned capture register.
// R09 - Selected firing event drives an output to its active level.
// R10 - Selected firing event drives an output to its inactive level.
// R11 - Selected firing event inverts an output's present level.
// R12 - Limit event zeroes counter or reverses direction in bidirectional mode.
// R13 - In bidirectional mode event may be limited to up, down or both.
// R14 - Firing event sets its status flag; enabled flag raises interrupt.
// R15 - Software clears any subset of status flags with a bit mask.
// R16 - Software halts or releases each counter through control bits.
// R17 - Halt event halts counter and blocks events until software releases.
// R18 - Unify bit set to one selects unified 32-bit operation.
// R19 - All event effects land on the same rising edge as detection.
// R20 - Reset clears counters, state, flags, enables and leaves counters halted.
`default_nettype none
module state_event_timer
  import set_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  input  wire apb_req_t        apb_i,
  output apb_rsp_t             apb_o,
  input  wire logic [NIN-1:0]  in_i,
  output logic [NOUT-1:0]      out_o,
  output logic                 irq_o
);

  state_t         r;
  state_t         n;
  logic [NEV-1:0] fire;

  // ==========================================================
  // Counter step
  function automatic logic [32:0] adv(input logic [31:0] v, input logic bd,
                                      input logic dn, input logic lim);
    logic nd;
    nd = dn;
    // R12 limit action
    if (lim && bd)
      nd = ~dn;
    if (bd && dn && (v == 32'h0000_0000) && !lim)
      nd = 1'b0;
    if (lim && !bd)
      adv = {nd, 32'h0000_0000};
    else
      adv = {nd, nd ? v - 32'h0000_0001 : v + 32'h0000_0001};
  endfunction

  // ==========================================================
  // Address decode
  function automatic logic mapped(input logic [11:0] a);
    mapped = 1'b0;
    if (a[1:0] == 2'h0) begin
      if (a <= A_HALT)
        mapped = 1'b1;
      if ((a[11:6] == A_EVREG) && (a[3:2] != 2'h3))
        mapped = 1'b1;
      if ((a[11:4] == A_MATCH) || (a[11:4] == A_CAPT))
        mapped = 1'b1;
    end
  endfunction

  assign apb_o.pready  = 1'b1;
  assign apb_o.pslverr = apb_i.psel & apb_i.penable & ~mapped(apb_i.paddr);
  assign apb_o.prdata  = r.prdata;
  assign out_o         = r.outs;
  // R14 interrupt request
  assign irq_o         = |(r.flags & r.ien);

  // ==========================================================
  // Next state
  always_comb begin
    logic            hs;
    logic            bd;
    logic            dn;
    logic            io_ok;
    logic            dir_ok;
    logic            mt;
    logic            wr;
    logic [4:0]      st;
    logic [4:0]      sv;
    logic [31:0]     cv;
    logic [31:0]     mv;
    logic [31:0]     ec;
    logic [31:0]     rd;
    logic [31:0]     wd;
    logic [11:0]     a;
    logic [32:0]     s;
    logic [NOUT-1:0] sm;
    logic [NOUT-1:0] cm;
    logic [NOUT-1:0] tm;
    hs     = 1'b0;
    bd     = 1'b0;
    dn     = 1'b0;
    io_ok  = 1'b0;
    dir_ok = 1'b0;
    mt     = 1'b0;
    st     = 5'h00;
    sv     = 5'h00;
    cv     = 32'h0000_0000;
    mv     = 32'h0000_0000;
    ec     = 32'h0000_0000;
    rd     = 32'h0000_0000;
    s      = 33'h0_0000_0000;
    sm     = '0;
    cm     = '0;
    tm     = '0;
    fire   = '0;
    n      = r;
    a      = apb_i.paddr;
    wd     = apb_i.pwdata;
    // Refused addresses must not reach the event or match registers
    wr     = apb_i.psel & apb_i.penable & apb_i.pwrite & mapped(apb_i.paddr);

    // ========================================================
    // Software writes
    if (wr) begin
      case (a)
        // R18 unify select
        A_CONFIG: n.unify = wd[CF_UNIFY];
        A_CTRL: begin
          // R16 halt and release
          n.halt_l  = wd[CT_HALT_L];
          n.up_down_counting_l = wd[CT_UP_DOWN_COUNTING_L];
          n.halt_h  = wd[CT_HALT_H];
          n.up_down_counting_h = wd[CT_UP_DOWN_COUNTING_H];
        end
        A_COUNT: begin
          if (r.unify) begin
            if (r.halt_l)
              n.cnt = wd;
          end else begin
            if (r.halt_l)
              n.cnt[15:0] = wd[15:0];
            if (r.halt_h)
              n.cnt[31:16] = wd[31:16];
          end
        end
        A_STATE: begin
          // R02 halted-only state write
          if (r.halt_l)
            n.st_l = wd[4:0];
          if (r.halt_h && !r.unify)
            n.st_h = wd[ST_H+:5];
        end
        // R15 mask clear
        A_FLAG: n.flags = r.flags & ~wd[NEV-1:0];
        A_IEN:  n.ien = wd[NEV-1:0];
        A_OUT:  n.outs = wd[NOUT-1:0];
        A_LIMIT: begin
          n.lim_l = wd[NEV-1:0];
          n.lim_h = wd[SEL_H+:NEV];
        end
        A_HALT: begin
          n.hlt_l = wd[NEV-1:0];
          n.hlt_h = wd[SEL_H+:NEV];
        end
        default: begin
          if (a[11:6] == A_EVREG) begin
            if (a[3:2] == W_MASK)
              n.ev_mask[a[5:4]] = wd;
            if (a[3:2] == W_CTRL)
              n.ev_ctrl[a[5:4]] = wd;
            if (a[3:2] == W_ACT)
              n.ev_act[a[5:4]] = wd[15:0];
          end
          if (a[11:4] == A_MATCH)
            n.mr[a[3:2]] = wd;
        end
      endcase
    end

    // ========================================================
    // Event evaluation and actions
    for (int e = 0; e < NEV; e++) begin
      ec = r.ev_ctrl[e];
      // R01 half selection
      hs = ec[EV_USEH] & ~r.unify;
      // R03 five-bit state
      st = hs ? r.st_h : r.st_l;
      bd = hs ? r.up_down_counting_h : r.up_down_counting_l;
      dn = hs ? r.dn_h : r.dn_l;
      cv = r.unify ? r.cnt : (hs ? {16'h0000, r.cnt[31:16]} : {16'h0000, r.cnt[15:0]});
      mv = r.mr[ec[EV_MSEL+:2]];
      if (!r.unify)
        mv = hs ? {16'h0000, mv[31:16]} : {16'h0000, mv[15:0]};
      // R07 match and io condition
      mt = (cv == mv);
      unique case (ec[EV_IOC+:2])
        2'h0: io_ok = 1'b1;
        2'h1: io_ok = in_i[ec[EV_IOS+:3]];
        2'h2: io_ok = ~in_i[ec[EV_IOS+:3]];
        2'h3: io_ok = r.outs[ec[EV_IOS+:2]];
      endcase
      // R13 direction qualifier
      dir_ok = ~bd | (ec[EV_DIR+:2] == 2'h0) | ((ec[EV_DIR+:2] == 2'h1) & ~dn)
             | ((ec[EV_DIR+:2] == 2'h2) & dn);
      // R06 state mask, R17 halted blocks
      fire[e] = ~(hs ? r.halt_h : r.halt_l) & r.ev_mask[e][st] & dir_ok & io_ok
              & (ec[EV_MEN] ? mt : (ec[EV_IOC+:2] != 2'h0));
      if (fire[e]) begin
        sm = sm | r.ev_act[e][AC_SET+:NOUT];
        cm = cm | r.ev_act[e][AC_CLR+:NOUT];
        tm = tm | r.ev_act[e][AC_TOG+:NOUT];
        // R08 capture
        for (int m = 0; m < NMR; m++) begin
          if (r.ev_act[e][AC_CAP+m]) begin
            if (r.unify)
              n.cr[m] = r.cnt;
            else if (hs)
              n.cr[m][31:16] = r.cnt[31:16];
            else
              n.cr[m][15:0] = r.cnt[15:0];
          end
        end
        // R04 load or add, R05 later event overrides
        if (ec[EV_STCH]) begin
          sv = ec[EV_SV+:5];
          if (hs)
            n.st_h = ec[EV_LOAD] ? sv : st + sv;
          else
            n.st_l = ec[EV_LOAD] ? sv : st + sv;
        end
      end
    end

    // R09 set, R10 clear wins, R11 toggle
    n.outs = ((n.outs ^ (tm & ~sm & ~cm)) | sm) & ~cm;
    if (fire != '0)
      n.outs = ((r.outs ^ (tm & ~sm & ~cm)) | sm) & ~cm;
    // R14 flag set wins
    n.flags = n.flags | fire;

    // ========================================================
    // Counters
    // R19 same-edge effects
    if (r.unify) begin
      if (!r.halt_l) begin
        s = adv(r.cnt, r.up_down_counting_l, r.dn_l, |(fire & r.lim_l));
        n.cnt  = s[31:0];
        n.dn_l = s[32];
      end
    end else begin
      if (!r.halt_l) begin
        s = adv({16'h0000, r.cnt[15:0]}, r.up_down_counting_l, r.dn_l, |(fire & r.lim_l));
        n.cnt[15:0] = s[15:0];
        n.dn_l      = s[32];
      end
      if (!r.halt_h) begin
        s = adv({16'h0000, r.cnt[31:16]}, r.up_down_counting_h, r.dn_h, |(fire & r.lim_h));
        n.cnt[31:16] = s[15:0];
        n.dn_h       = s[32];
      end
    end
    // R17 halt event
    n.halt_l = n.halt_l | (|(fire & r.hlt_l));
    n.halt_h = n.halt_h | (|(fire & r.hlt_h) & ~r.unify);

    // ========================================================
    // Read data, latched in setup phase
    case (a)
      A_CONFIG: rd[CF_UNIFY] = r.unify;
      A_CTRL: begin
        rd[CT_HALT_L]  = r.halt_l;
        rd[CT_UP_DOWN_COUNTING_L] = r.up_down_counting_l;
        rd[CT_HALT_H]  = r.halt_h;
        rd[CT_UP_DOWN_COUNTING_H] = r.up_down_counting_h;
      end
      A_COUNT: rd = r.cnt;
      A_STATE: begin
        rd[4:0]     = r.st_l;
        rd[ST_H+:5] = r.st_h;
      end
      A_FLAG: rd[NEV-1:0] = r.flags;
      A_IEN:  rd[NEV-1:0] = r.ien;
      A_OUT:  rd[NOUT-1:0] = r.outs;
      A_LIMIT: begin
        rd[NEV-1:0]    = r.lim_l;
        rd[SEL_H+:NEV] = r.lim_h;
      end
      A_HALT: begin
        rd[NEV-1:0]    = r.hlt_l;
        rd[SEL_H+:NEV] = r.hlt_h;
      end
      default: begin
        if (a[11:6] == A_EVREG) begin
          if (a[3:2] == W_MASK)
            rd = r.ev_mask[a[5:4]];
          if (a[3:2] == W_CTRL)
            rd = r.ev_ctrl[a[5:4]];
          if (a[3:2] == W_ACT)
            rd[15:0] = r.ev_act[a[5:4]];
        end
        if (a[11:4] == A_MATCH)
          rd = r.mr[a[3:2]];
        if (a[11:4] == A_CAPT)
          rd = r.cr[a[3:2]];
      end
    endcase
    if (!mapped(a))
      rd = 32'h0000_0000;
    if (apb_i.psel && !apb_i.penable && !apb_i.pwrite)
      n.prdata = rd;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // R20 reset values
      r        <= '0;
      r.halt_l <= RST_HALT;
      r.halt_h <= RST_HALT;
    end else begin
      r <= n;
    end
  end

endmodule // state_event_timer
`default_nettype wire

// file: design/set_pkg.sv
`default_nettype none
package set_pkg;
  // ==========================================================
  // Sizes
  localparam int NEV  = 4;
  localparam int NOUT = 4;
  localparam int NMR  = 4;
  localparam int NIN  = 8;
  localparam int HW   = 16;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] A_CONFIG = 12'h000;
  localparam logic [11:0] A_CTRL   = 12'h004;
  localparam logic [11:0] A_COUNT  = 12'h008;
  localparam logic [11:0] A_STATE  = 12'h00C;
  localparam logic [11:0] A_FLAG   = 12'h010;
  localparam logic [11:0] A_IEN    = 12'h014;
  localparam logic [11:0] A_OUT    = 12'h018;
  localparam logic [11:0] A_LIMIT  = 12'h01C;
  localparam logic [11:0] A_HALT   = 12'h020;
  localparam logic [5:0]  A_EVREG  = 6'h01;
  localparam logic [7:0]  A_MATCH  = 8'h08;
  localparam logic [7:0]  A_CAPT   = 8'h09;
  localparam logic [1:0]  W_MASK   = 2'h0;
  localparam logic [1:0]  W_CTRL   = 2'h1;
  localparam logic [1:0]  W_ACT    = 2'h2;

  // ==========================================================
  // Field positions
  localparam int CF_UNIFY   = 0;
  localparam int CT_HALT_L  = 0;
  localparam int CT_UP_DOWN_COUNTING_L = 1;
  localparam int CT_HALT_H  = 16;
  localparam int CT_UP_DOWN_COUNTING_H = 17;
  localparam int ST_H       = 16;
  localparam int SEL_H      = 16;
  localparam int EV_MSEL    = 0;
  localparam int EV_USEH    = 2;
  localparam int EV_MEN     = 3;
  localparam int EV_IOC     = 4;
  localparam int EV_IOS     = 6;
  localparam int EV_LOAD    = 9;
  localparam int EV_STCH    = 10;
  localparam int EV_DIR     = 11;
  localparam int EV_SV      = 16;
  localparam int AC_SET     = 0;
  localparam int AC_CLR     = 4;
  localparam int AC_TOG     = 8;
  localparam int AC_CAP     = 12;

  // ==========================================================
  // Reset values
  localparam logic RST_HALT = 1'b1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic                     unify;
    logic                     halt_l;
    logic                     halt_h;
    logic                     up_down_counting_l;
    logic                     up_down_counting_h;
    logic                     dn_l;
    logic                     dn_h;
    logic [31:0]              cnt;
    logic [4:0]               st_l;
    logic [4:0]               st_h;
    logic [NEV-1:0]           flags;
    logic [NEV-1:0]           ien;
    logic [NOUT-1:0]          outs;
    logic [NEV-1:0]           lim_l;
    logic [NEV-1:0]           lim_h;
    logic [NEV-1:0]           hlt_l;
    logic [NEV-1:0]           hlt_h;
    logic [NEV-1:0][31:0]     ev_mask;
    logic [NEV-1:0][31:0]     ev_ctrl;
    logic [NEV-1:0][15:0]     ev_act;
    logic [NMR-1:0][31:0]     mr;
    logic [NMR-1:0][31:0]     cr;
    logic [31:0]              prdata;
  } state_t;
endpackage
`default_nettype wire

// file: sim/set_checker.sv
`default_nettype none
module set_checker
  import set_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            nrst_i,
  input wire apb_req_t        apb_i,
  input wire apb_rsp_t        apb_o,
  input wire logic [NIN-1:0]  in_i,
  input wire logic [NOUT-1:0] out_o,
  input wire logic            irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  logic acc;
  logic wr;
  logic halted_q;
  assign acc = apb_i.psel & apb_i.penable;
  assign wr  = acc & apb_i.pwrite;

  // ==========================================================
  // Both counters known halted
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      halted_q <= 1'b1;
    end else if (wr && apb_i.paddr == A_CTRL) begin
      halted_q <= apb_i.pwdata[CT_HALT_L] & apb_i.pwdata[CT_HALT_H];
    end
  end

  sequence out_wr;
    halted_q && wr && apb_i.paddr == A_OUT;
  endsequence

  sequence flag_all_clr;
    halted_q && wr && apb_i.paddr == A_FLAG && apb_i.pwdata[NEV-1:0] == 4'hF;
  endsequence

  // ==========================================================
  // Properties
  ready_zero_wait_a : assert property (acc |-> apb_o.pready)
    else $error("pready low in access phase");
  err_phase_a : assert property (apb_o.pslverr |-> acc)
    else $error("pslverr outside access phase");
  err_misalign_a : assert property (acc && apb_i.paddr[1:0] != 2'h0 |-> apb_o.pslverr)
    else $error("misaligned access not refused");
  read_hold_a : assert property (acc && !apb_i.pwrite |=> $stable(apb_o.prdata))
    else $error("read data moved after access");
  out_write_a : assert property (out_wr |=> out_o == $past(apb_i.pwdata[NOUT-1:0]))
    else $error("output register write lost");
  out_quiet_a : assert property (halted_q && !(wr && apb_i.paddr == A_OUT)
    |=> $stable(out_o))
    else $error("outputs moved while halted");
  irq_quiet_a : assert property (halted_q && !(wr && (apb_i.paddr == A_FLAG
    || apb_i.paddr == A_IEN)) |=> $stable(irq_o))
    else $error("irq moved while halted");
  irq_mask_a : assert property (wr && apb_i.paddr == A_IEN && apb_i.pwdata[NEV-1:0] == 4'h0
    |=> !irq_o)
    else $error("irq high with no enables");
  flag_clear_a : assert property (flag_all_clr |=> !irq_o)
    else $error("irq high after clearing all flags");
  reset_quiet_a : assert property ($rose(nrst_i) |-> out_o == 4'h0 && !irq_o)
    else $error("outputs not cleared by reset");
endmodule // set_checker

bind state_event_timer set_checker chk (
  .clk_i  (clk_i),
  .nrst_i (nrst_i),
  .apb_i  (apb_i),
  .apb_o  (apb_o),
  .in_i   (in_i),
  .out_o  (out_o),
  .irq_o  (irq_o)
);
`default_nettype wire

// file: sim/testbench.sv
`default_nettype none
module testbench
  import set_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk_i = 1'b0;
  logic            nrst_i = 1'b0;
  apb_req_t        apb_i = '0;
  apb_rsp_t        apb_o;
  logic [NIN-1:0]  in_i = '0;
  logic [NOUT-1:0] out_o;
  logic            irq_o;
  logic [31:0]     rd;
  int              fail_count = 0;
  int              comparisons = 0;

  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end

  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) in_i <= NIN'($urandom);

  state_event_timer dut (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .apb_i  (apb_i),
    .apb_o  (apb_o),
    .in_i   (in_i),
    .out_o  (out_o),
    .irq_o  (irq_o)
  );

  // ==========================================================
  // Bus and verdict tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic ee);
    @(posedge clk_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    `CHK(apb_o.pslverr, ee)
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    `CHK(rd, e)
  endtask

  function automatic logic [4:0] nxt(int s, int v, bit ld);
    return ld ? 5'(v) : 5'((s + v) % 32);
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    int st;
    int sv;
    int m;
    int n;
    logic [31:0] c;
    void'($urandom(53977));
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk(A_CTRL, 32'h0001_0001);
    rd_chk(A_COUNT, 32'h0);
    rd_chk(A_STATE, 32'h0);
    apb(1'b0, 12'h0FE, 32'h0, 1'b1);
    wr(A_CONFIG, 32'h1);
    for (int i = 0; i < 3; i++) begin
      st = $urandom_range(31);
      sv = $urandom_range(31);
      m  = $urandom_range(40, 8);
      wr(A_CTRL, 32'h0001_0001);
      wr(A_OUT, 32'h0);
      wr(A_FLAG, 32'hF);
      wr(A_COUNT, 32'h0);
      wr(A_STATE, st);
      rd_chk(A_STATE, st);
      wr(12'h080, m);
      wr(12'h040, i == 2 ? ~(32'h1 << st) : 32'hFFFF_FFFF);
      wr(12'h044, (sv << EV_SV) | (1 << EV_STCH) | ((i != 0) << EV_LOAD) | (1 << EV_MEN));
      wr(12'h048, (1 << i) | (1 << AC_CAP));
      wr(A_HALT, 32'h1);
      wr(A_IEN, 32'h1);
      wr(A_CTRL, 32'h0001_0000);
      wr(A_STATE, st ^ 1);
      n = 0;
      while (out_o[i] !== 1'b1 && n < 100) begin
        @(posedge clk_i);
        n++;
      end
      #1;
      `CHK(out_o, (i < 2) ? 4'(1 << i) : 4'h0)
      `CHK(irq_o, i < 2)
      rd_chk(A_FLAG, (i < 2) ? 32'h1 : 32'h0);
      apb(1'b0, A_STATE, 32'h0, 1'b0);
      `CHK(rd[4:0], (i < 2) ? nxt(st, sv, i != 0) : 5'(st))
      if (i < 2) begin
        rd_chk(12'h090, m);
        apb(1'b0, A_COUNT, 32'h0, 1'b0);
        c = rd;
        rd_chk(A_COUNT, c);
        wr(A_FLAG, 32'h1);
        #1;
        `CHK(irq_o, 1'b0)
      end
    end
    wr(A_CTRL, 32'h0001_0001);
    wr(A_IEN, 32'h0);
    // ==========================================================
    // Split halves, limit, toggle, priority
    st = $urandom_range(31);
    sv = $urandom_range(31);
    wr(A_CONFIG, 32'h0);
    wr(A_FLAG, 32'hF);
    wr(A_COUNT, 32'h0);
    wr(A_OUT, 32'h4);
    wr(A_STATE, (st << ST_H) | 2);
    for (int e = 0; e < NEV; e++) begin
      wr(12'h040 + 12'(16 * e), 32'hFFFF_FFFF);
    end
    wr(12'h080, 32'h0000_0005);
    wr(12'h084, 32'h0003_0000);
    wr(12'h044, (9 << EV_SV) | (1 << EV_STCH) | (1 << EV_LOAD) | (1 << EV_MEN));
    wr(12'h048, (1 << AC_TOG) | (1 << (AC_CLR + 2)));
    wr(12'h054, (sv << EV_SV) | (1 << EV_STCH) | (2 << EV_IOS) | (3 << EV_IOC)
       | (1 << EV_MEN) | (1 << EV_USEH) | 1);
    wr(12'h058, (1 << (AC_CAP + 1)) | (1 << (AC_TOG + 3)) | (1 << 1));
    wr(12'h064, (17 << EV_SV) | (1 << EV_DIR) | (1 << EV_STCH) | (1 << EV_LOAD)
       | (1 << EV_MEN));
    wr(12'h068, 1 << 2);
    wr(12'h074, (25 << EV_SV) | (2 << EV_DIR) | (1 << EV_STCH) | (1 << EV_LOAD)
       | (1 << EV_MEN));
    wr(12'h078, 1 << AC_CLR);
    wr(A_LIMIT, 32'h0000_0001);
    wr(A_HALT, 32'h0002_0001);
    wr(A_CTRL, 32'h0000_0002);
    repeat (12) @(posedge clk_i);
    #1;
    `CHK(out_o, 4'hB)
    `CHK(out_o[2], 1'b0)
    rd_chk(A_COUNT, 32'h0004_0004);
    rd_chk(A_STATE, (32'(nxt(st, sv, 1'b0)) << ST_H) | 32'h11);
    rd_chk(A_FLAG, 32'h7);
    rd_chk(12'h094, 32'h0003_0000);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
